// ===== rtl/hkc_housekeeping_clock_unit.sv
// Purpose: housekeeping oscillator with programmable timer divider
// Assumes: clk at 200 MHz stands in for the internal oscillator
// Notes: the divider reset acts without any clock edge
//
// Behaviour
// - Oscillator stays off after reset until explicitly enabled.
// - Enabled oscillator supplies undivided clock at nominal 5 MHz.
// - Runtime stop input from fabric logic gates the oscillator off.
// - Twenty-bit divider gives roughly 5 Hz divided output.
// - Raw and divided clocks run together; ten bits gives about 5 kHz.
// - Raw and divided clocks optionally drive global routing pool lines.
// - Two cells' feedback muxes choose cell feedback or timer output.
// - Divider reset asynchronously forces divided output low.
// - Seven, ten or twenty bit lengths; update on raw falling edge.
`timescale 1ns/1ps
module hkc_housekeeping_clock_unit #(
  parameter int HALF_CYC = hkc_pkg::RAW_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic oscEnable,
  input wire logic runtime_clock_stop,
  input wire logic divider_reset_in,
  input hkc_pkg::hkc_len_t divLength,
  input hkc_pkg::hkc_route_t routeCfg,
  input wire logic cell0Feedback,
  input wire logic cell1Feedback,
  output logic raw_clock_out,
  output logic divided_clock_out,
  output logic rawPoolLine,
  output logic divPoolLine,
  output logic cell0PoolLine,
  output logic cell1PoolLine
);
  import hkc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  hkc_state_t state_r, state_nxt;
  logic [HALF_W-1:0] half_r, half_nxt;
  logic raw_r, raw_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic tap;
  logic divOut_r, divOut_nxt;
  logic rawPool_r, rawPool_nxt;
  logic divPool_r, divPool_nxt;
  logic fallEdge;
  logic [HALF_W-1:0] halfLast;

  assign halfLast = HALF_W'(HALF_CYC - 1);

  // ----------------------------------------
  // Oscillator
  // ----------------------------------------
  // Stop wins over enable so fabric can gate at run time
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HKC_OFF: begin
        if (oscEnable && !runtime_clock_stop) begin
          state_nxt = HKC_RUN;
        end
      end
      HKC_RUN: begin
        if (!oscEnable || runtime_clock_stop) begin
          state_nxt = HKC_OFF;
        end
      end
      default: begin
        state_nxt = HKC_OFF;
      end
    endcase
  end

  // Half-period counter; frozen when off, so the raw level holds
  always_comb begin
    half_nxt = half_r;
    raw_nxt = raw_r;
    fallEdge = 1'b0;
    if (state_r == HKC_RUN) begin
      if (half_r == halfLast) begin
        half_nxt = '0;
        raw_nxt = ~raw_r;
        fallEdge = raw_r;
      end else begin
        half_nxt = half_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= HKC_OFF;
      half_r <= '0;
      raw_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      half_r <= half_nxt;
      raw_r <= raw_nxt;
    end
  end

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // Tap is the top bit of the selected length
  always_comb begin
    case (divLength)
      HKC_DIV7: tap = div_r[LEN7-1];
      HKC_DIV10: tap = div_r[LEN10-1];
      HKC_DIV20: tap = div_r[LEN20-1];
      default: tap = div_r[LEN20-1];
    endcase
  end

  // Counts only on raw falling edges, both clocks run together
  always_comb begin
    div_nxt = div_r;
    divOut_nxt = divOut_r;
    if (fallEdge) begin
      div_nxt = div_r + 1'b1;
      divOut_nxt = tap;
    end
  end

  // Divider reset clears without a clock edge
  always_ff @(posedge clk or negedge rst_b or posedge divider_reset_in) begin
    if (!rst_b) begin
      div_r <= '0;
      divOut_r <= 1'b0;
    end else if (divider_reset_in) begin
      div_r <= '0;
      divOut_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      divOut_r <= divOut_nxt;
    end
  end

  // ----------------------------------------
  // Pool routing
  // ----------------------------------------
  // Unrouted pool lines rest low
  always_comb begin
    rawPool_nxt = routeCfg.rawToPool & raw_nxt;
    divPool_nxt = routeCfg.divToPool & divOut_nxt;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rawPool_r <= 1'b0;
      divPool_r <= 1'b0;
    end else begin
      rawPool_r <= rawPool_nxt;
      divPool_r <= divPool_nxt;
    end
  end

  assign raw_clock_out = raw_r;
  assign divided_clock_out = divOut_r;
  assign rawPoolLine = rawPool_r;
  assign divPoolLine = divPool_r;

  // Cell 0 takes raw clock, cell 1 the divided clock
  hkc_feedback_mux uMux0 (
    .clk(clk),
    .rst_b(rst_b),
    .useTimer(routeCfg.cell0UseTimer),
    .cellFeedback(cell0Feedback),
    .timerSignal(raw_r),
    .poolLine(cell0PoolLine)
  );

  hkc_feedback_mux uMux1 (
    .clk(clk),
    .rst_b(rst_b),
    .useTimer(routeCfg.cell1UseTimer),
    .cellFeedback(cell1Feedback),
    .timerSignal(divOut_r),
    .poolLine(cell1PoolLine)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence sRunFor2;
    state_r == HKC_RUN ##1 state_r == HKC_RUN;
  endsequence

  // Cycles the raw level has held, saturating; a counter instead of a
  // long repetition keeps the half-period check cheap to evaluate
  logic rawSeen_r, rawSeen_nxt;
  logic [HALF_W-1:0] rawHold_r, rawHold_nxt;

  always_comb begin
    rawSeen_nxt = raw_r;
    rawHold_nxt = rawHold_r;
    if (raw_r != rawSeen_r) begin
      rawHold_nxt = '0;
    end else if (rawHold_r != '1) begin
      rawHold_nxt = rawHold_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rawSeen_r <= 1'b0;
      rawHold_r <= '0;
    end else begin
      rawSeen_r <= rawSeen_nxt;
      rawHold_r <= rawHold_nxt;
    end
  end

  AST_OFF_AFTER_ENABLE_LOW: assert property (
    @(posedge clk) disable iff (!rst_b)
    !oscEnable |=> state_r == HKC_OFF)
    else $error("oscillator ran without enable");

  AST_STOP_GATES: assert property (
    @(posedge clk) disable iff (!rst_b)
    runtime_clock_stop |=> state_r == HKC_OFF)
    else $error("runtime stop ignored");

  AST_RAW_HALF_PERIOD: assert property (
    @(posedge clk) disable iff (!rst_b)
    $changed(raw_r) |-> rawHold_r >= halfLast)
    else $error("raw clock half period short");

  AST_STATIC_WHEN_OFF: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state_r == HKC_OFF) |=> $stable(raw_r))
    else $error("raw clock toggled while off");

  AST_DIV_ON_FALL: assert property (
    @(posedge clk) disable iff (!rst_b || divider_reset_in)
    $changed(divOut_r) |-> $past(fallEdge))
    else $error("divided output moved off a falling edge");

  AST_DIV_RESET_LOW: assert property (
    @(posedge clk) disable iff (!rst_b)
    divider_reset_in |-> !divOut_r)
    else $error("divided output high under reset");

  AST_RAW_POOL: assert property (
    @(posedge clk) disable iff (!rst_b)
    sRunFor2 |-> rawPoolLine == (raw_r & $past(routeCfg.rawToPool)))
    else $error("raw pool line wrong");

  AST_CELL_MUX: assert property (
    @(posedge clk) disable iff (!rst_b)
    ##1 cell1PoolLine == ($past(routeCfg.cell1UseTimer) ?
      $past(divOut_r) : $past(cell1Feedback)))
    else $error("cell feedback mux wrong");

endmodule

// ===== rtl/hkc_pkg.sv
// Purpose: constants and types for the housekeeping clock unit
// Assumes: one system clock at 200 MHz
// Notes: the raw clock is made from clk by a divider
package hkc_pkg;

  // ----------------------------------------
  // Clock figures
  // ----------------------------------------
  localparam int SYS_CLK_KHZ = 200000;
  localparam int RAW_CLK_KHZ = 5000;
  // Half period of the raw clock in system cycles
  localparam int RAW_HALF_CYC = SYS_CLK_KHZ / RAW_CLK_KHZ / 2;
  localparam int HALF_W = 5;

  // ----------------------------------------
  // Divider lengths
  // ----------------------------------------
  localparam int DIV_W = 20;
  localparam int LEN7 = 7;
  localparam int LEN10 = 10;
  localparam int LEN20 = 20;

  typedef enum logic [1:0] {
    HKC_DIV7 = 2'h0,
    HKC_DIV10 = 2'h1,
    HKC_DIV20 = 2'h2
  } hkc_len_t;

  // Oscillator state
  typedef enum logic [0:0] {
    HKC_OFF = 1'h0,
    HKC_RUN = 1'h1
  } hkc_state_t;

  // Routing selections for pool and the two feedback cells
  typedef struct packed {
    logic rawToPool;
    logic divToPool;
    logic cell0UseTimer;
    logic cell1UseTimer;
  } hkc_route_t;

  localparam logic RESET_LEVEL = 1'b0;

endpackage

// ===== rtl/hkc_feedback_mux.sv
// Purpose: feedback selection for the two designated logic cells
// Assumes: inputs synchronous to clk
// Notes: output registered
`timescale 1ns/1ps
module hkc_feedback_mux (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic useTimer,
  input wire logic cellFeedback,
  input wire logic timerSignal,
  output logic poolLine
);
  import hkc_pkg::*;

  logic poolLine_nxt;

  // --------------------------------
  // Selection
  // --------------------------------
  always_comb begin
    poolLine_nxt = useTimer ? timerSignal : cellFeedback;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      poolLine <= RESET_LEVEL;
    end else begin
      poolLine <= poolLine_nxt;
    end
  end

endmodule

// ===== tb/hkc_fabric_model.sv
// Purpose: fabric logic cells around the clock unit
// Assumes: bench moves requests on the falling edge
// Notes: cells pass requests straight through
`timescale 1ns/1ps
module hkc_fabric_model (
  input wire logic [1:0] rnd,
  input wire logic stopReq,
  input wire logic clrReq,
  output logic cell0Fb,
  output logic cell1Fb,
  output logic stopOut,
  output logic clrOut
);
  // Cell outputs; no delay, so mid-cycle reset stays mid-cycle
  assign stopOut = stopReq;
  assign clrOut = clrReq;
  assign {cell1Fb, cell0Fb} = rnd;
endmodule

// ===== tb/hkc_housekeeping_clock_unit_tb.sv
// Purpose: self-checking bench of the clock unit
// Assumes: inputs change on the falling edge
// Notes: 20-bit length only checked for no early edge
`timescale 1ns/1ps
module hkc_housekeeping_clock_unit_tb;
  import hkc_pkg::*;
  logic clk = 0, rst_b = 0, en = 0, stopReq = 0, clrReq = 0;
  logic [7:0] lfsr = 8'h47;
  hkc_len_t len = HKC_DIV7;
  hkc_route_t cfg, pCfg;
  logic f0, f1, stp, clr, raw, dv, rawP, divP, c0P, c1P;
  logic pRaw, pDiv, pF0, pF1, armed = 0;
  int bad_count = 0, total_checks = 0, cyc = 0, n;
  assign cfg = hkc_route_t'(lfsr[3:0]);
  always #2.5 clk = ~clk;
  function automatic logic [7:0] nextLfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Random routing and cell feedback each cycle
  always @(negedge clk) lfsr <= nextLfsr(lfsr);
  hkc_fabric_model hkc_fabric_model_i (.rnd(lfsr[5:4]),
    .stopReq(stopReq), .clrReq(clrReq), .cell0Fb(f0), .cell1Fb(f1),
    .stopOut(stp), .clrOut(clr));
  hkc_housekeeping_clock_unit hkc_housekeeping_clock_unit_i (.clk(clk),
    .rst_b(rst_b), .oscEnable(en), .runtime_clock_stop(stp),
    .divider_reset_in(clr), .divLength(len), .routeCfg(cfg),
    .cell0Feedback(f0), .cell1Feedback(f1), .raw_clock_out(raw),
    .divided_clock_out(dv), .rawPoolLine(rawP), .divPoolLine(divP),
    .cell0PoolLine(c0P), .cell1PoolLine(c1P));
  task automatic chkBit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t bit got %b", $time, g);
    end
  endtask
  task automatic chkNum(input int g, input int e);
    total_checks++;
    if (g != e) begin
      bad_count++;
      $display("MISMATCH t=%0t count %0d not %0d", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cycles until the chosen output moves; -1 if it does not move within lim cycles
  task automatic meas(input bit useDiv, input int lim, output int k);
    logic s0;
    s0 = useDiv ? dv : raw;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while ((useDiv ? dv : raw) === s0 && k < lim);
    if (k >= lim) k = -1;
  endtask
  task automatic clrPulse;
    clrReq = 1;
    @(negedge clk);
    clrReq = 0;
  endtask
  // Pool model: pool lines follow the new clock level, cell lines the old
  always @(posedge clk) begin
    armed <= rst_b;
    {pRaw, pDiv, pF0, pF1, pCfg} = {raw, dv, f0, f1, cfg};
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      report_and_stop;
    end
  end
  always @(negedge clk) begin
    if (armed) begin
      chkBit(rawP, pCfg.rawToPool & raw);
      chkBit(divP, pCfg.divToPool & dv);
      chkBit(c0P, pCfg.cell0UseTimer ? pRaw : pF0);
      chkBit(c1P, pCfg.cell1UseTimer ? pDiv : pF1);
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1;
    meas(0, 50, n);
    chkNum(n, -1);
    chkBit(dv, 1'b0);
    en = 1;
    meas(0, 30, n);
    chkNum(n >= 20 && n <= 22, 1);
    repeat (2) begin
      meas(0, 30, n);
      chkNum(n, 20);
    end
    $display("test oscillator done");
    clrPulse;
    meas(1, 9000, n);
    chkBit(raw, 1'b0);
    repeat (2) begin
      meas(1, 9000, n);
      chkNum(n, 2560);
    end
    chkBit(dv, 1'b1);
    clrReq = 1;
    #1;
    chkBit(dv, 1'b0);
    @(negedge clk);
    clrReq = 0;
    $display("test seven bit done");
    stopReq = 1;
    repeat (3) @(negedge clk);
    meas(0, 200, n);
    chkNum(n, -1);
    chkBit(dv, 1'b0);
    stopReq = 0;
    meas(0, 30, n);
    chkNum(n > 0 && n <= 22, 1);
    $display("test stop done");
    len = HKC_DIV10;
    clrPulse;
    meas(1, 30000, n);
    meas(1, 30000, n);
    chkNum(n, 20480);
    len = HKC_DIV20;
    clrPulse;
    meas(1, 6000, n);
    chkNum(n, -1);
    $display("test long lengths done");
    report_and_stop;
  end
endmodule
